// ### rtl/swc_pkg.sv
// constants and register map of the sleep and wake controller
//
// Behaviour
// - sleep clears watchdog, power-down flag; sets timeout
// - enabled watchdog keeps counting while asleep
// - oscillator stopped in sleep, clocked peripherals silent
// - io ports hold their drive during sleep
// - master clear resets; watchdog, interrupt resume
// - watchdog wake clears the timeout flag
// - only eight listed peripheral sources can wake
// - wake needs individual enable, ignores global enable
// - after wake run next op, then vector if enabled
// - sleep prefetches next sequential instruction address
// - watchdog cleared on every wake
// - pending enabled interrupt makes sleep a no-op
// - interrupt during sleep: complete sleep, wake at once
// - power-down flag set at power-up, cleared entering sleep
// - watchdog reset stays internal, pin not driven
package swc_pkg;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0]  CTRL_OFS      = 8'h00;
    localparam logic [7:0]  WAKE_EN_OFS   = 8'h04;
    localparam logic [7:0]  STATUS_OFS    = 8'h08;
    localparam logic [7:0]  INT_STAT_OFS  = 8'h0c;
    localparam logic [7:0]  INT_MASK_OFS  = 8'h10;
    localparam logic [7:0]  WDT_CNT_OFS   = 8'h14;

    // ----------------------------------------------------------------
    // reset values and fixed codes
    // ----------------------------------------------------------------
    localparam logic        PD_RESET      = 1'b1;
    localparam logic        TO_RESET      = 1'b1;
    localparam logic [12:0] IRQ_VECTOR    = 13'h0004;
    localparam logic [12:0] PC_STEP       = 13'h0001;
    localparam int          NUM_SRC       = 8;
    localparam int          NUM_EVT       = 4;
    // interrupt status bits
    localparam int          EVT_SLEEP     = 0;
    localparam int          EVT_WAKE_IRQ  = 1;
    localparam int          EVT_WAKE_WDT  = 2;
    localparam int          EVT_RESET     = 3;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int          CLK_PERIOD_NS = 25;
    localparam int          OSC_START_NS  = 1000;
    localparam int          OSC_START_CYC = (OSC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0]
    {
        SWC_RUN   = 2'b00,
        SWC_SLEEP = 2'b01,
        SWC_START = 2'b10
    } swc_mode_t;

endpackage

// ### rtl/sleep_wake_control.sv
// sleep entry, wake detection, watchdog and status flags with apb registers
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ps
module sleep_wake_control
    import swc_pkg::*;
#(
    parameter int WDT_W = 16
)
(
    input  wire logic                clk,
    input  wire logic                reset,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                sleepExec,
    input  wire logic [12:0]         pcValue,
    input  wire logic                watchdogClearOp,
    input  wire logic                wdtTick,
    input  wire logic [NUM_SRC-1:0]  irqFlags,
    input  wire logic                globalIrqEnable,
    input  wire logic                masterClearPinN,
    output logic                     oscEnable,
    output logic                     ioHold,
    output logic                     fetchReq,
    output logic      [12:0]         fetchAddr,
    output logic                     resumeExec,
    output logic                     vectorReq,
    output logic      [12:0]         vectorAddr,
    output logic                     deviceReset,
    output logic                     powerDownFlag,
    output logic                     timeoutFlag,
    output logic                     irqOut
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    localparam int OSC_W = $clog2(OSC_START_CYC + 1);
    localparam logic [OSC_W-1:0] OSC_LAST = OSC_W'(OSC_START_CYC - 1);

    typedef struct packed
    {
        swc_mode_t            mode;
        logic                 pdFlag;
        logic                 toFlag;
        logic [WDT_W-1:0]     wdtCnt;
        logic [OSC_W-1:0]     oscCnt;
        logic                 wakeByIrq;
        logic                 wdtEn;
        logic [NUM_SRC-1:0]   wakeEn;
        logic [NUM_EVT-1:0]   intStat;
        logic [NUM_EVT-1:0]   intMask;
        logic [31:0]          rdata;
        logic                 slvErr;
        logic                 fetch;
        logic [12:0]          nextPc;
        logic                 resume;
        logic                 vector;
        logic                 devRst;
    } swc_state_t;

    swc_state_t cur_ff;
    swc_state_t nxt_cur;

    logic                 setupPh;
    logic                 accessWr;
    logic                 mapped;
    logic                 wakePending;
    logic                 wdtExpire;
    logic                 mclrActive;
    logic [NUM_EVT-1:0]   evt;
    logic [NUM_EVT-1:0]   w1c;

    // ----------------------------------------------------------------
    // combinational next state
    // ----------------------------------------------------------------
    always_comb
    begin
        nxt_cur     = cur_ff;
        evt         = '0;
        w1c         = '0;
        setupPh     = psel && !penable;
        accessWr    = psel && penable && pwrite;
        mapped      = (paddr == CTRL_OFS) || (paddr == WAKE_EN_OFS) ||
                      (paddr == STATUS_OFS) || (paddr == INT_STAT_OFS) ||
                      (paddr == INT_MASK_OFS) || (paddr == WDT_CNT_OFS);
        wakePending = |(irqFlags & cur_ff.wakeEn);
        wdtExpire   = cur_ff.wdtEn && wdtTick && (&cur_ff.wdtCnt);
        mclrActive  = !masterClearPinN;

        nxt_cur.fetch  = 1'b0;
        nxt_cur.resume = 1'b0;
        nxt_cur.vector = 1'b0;
        nxt_cur.devRst = 1'b0;

        // watchdog counting, awake and asleep
        // runs while asleep
        if (cur_ff.wdtEn && wdtTick)
        begin
            nxt_cur.wdtCnt = cur_ff.wdtCnt + WDT_W'(1);
        end
        if (watchdogClearOp && cur_ff.mode == SWC_RUN)
        begin
            nxt_cur.wdtCnt = '0;
        end

        unique case (cur_ff.mode)
            SWC_RUN:
            begin
                if (cur_ff.resume && cur_ff.wakeByIrq && globalIrqEnable)
                begin
                    nxt_cur.vector = 1'b1;
                end
                if (wdtExpire)
                begin
                    nxt_cur.devRst = 1'b1;
                    nxt_cur.toFlag = 1'b0;
                    nxt_cur.wdtCnt = '0;
                    evt[EVT_RESET] = 1'b1;
                end
                else if (sleepExec && !wakePending)
                begin
                    nxt_cur.wdtCnt = '0;
                    nxt_cur.pdFlag = 1'b0;
                    nxt_cur.toFlag = 1'b1;
                    nxt_cur.fetch  = 1'b1;
                    nxt_cur.nextPc = pcValue + PC_STEP;
                    nxt_cur.mode   = SWC_SLEEP;
                    evt[EVT_SLEEP] = 1'b1;
                end
                // pending enabled flag leaves all untouched
            end
            SWC_SLEEP:
            begin
                if (mclrActive)
                begin
                    nxt_cur.devRst = 1'b1;
                    nxt_cur.wdtCnt = '0;
                    nxt_cur.mode   = SWC_RUN;
                    evt[EVT_RESET] = 1'b1;
                end
                else if (wdtExpire)
                begin
                    nxt_cur.toFlag    = 1'b0;
                    nxt_cur.wdtCnt    = '0;
                    nxt_cur.wakeByIrq = 1'b0;
                    nxt_cur.oscCnt    = '0;
                    nxt_cur.mode      = SWC_START;
                    evt[EVT_WAKE_WDT] = 1'b1;
                end
                else if (wakePending)
                begin
                    nxt_cur.wdtCnt    = '0;
                    nxt_cur.wakeByIrq = 1'b1;
                    nxt_cur.oscCnt    = '0;
                    nxt_cur.mode      = SWC_START;
                    evt[EVT_WAKE_IRQ] = 1'b1;
                end
            end
            SWC_START:
            begin
                if (mclrActive)
                begin
                    nxt_cur.devRst = 1'b1;
                    nxt_cur.mode   = SWC_RUN;
                    evt[EVT_RESET] = 1'b1;
                end
                else if (cur_ff.oscCnt == OSC_LAST)
                begin
                    nxt_cur.resume = 1'b1;
                    nxt_cur.mode   = SWC_RUN;
                end
                else
                begin
                    nxt_cur.oscCnt = cur_ff.oscCnt + OSC_W'(1);
                end
            end
            default:
            begin
                nxt_cur.mode = SWC_RUN;
            end
        endcase

        // register writes, taken in the access phase
        if (accessWr)
        begin
            unique case (paddr)
                CTRL_OFS:     nxt_cur.wdtEn   = pwdata[0];
                WAKE_EN_OFS:  nxt_cur.wakeEn  = pwdata[NUM_SRC-1:0];
                INT_STAT_OFS: w1c             = pwdata[NUM_EVT-1:0];
                INT_MASK_OFS: nxt_cur.intMask = pwdata[NUM_EVT-1:0];
                default:      ;
            endcase
        end
        // set wins over a write-one clear in the same cycle
        nxt_cur.intStat = (cur_ff.intStat & ~w1c) | evt;

        // read data and error prepared in the setup phase
        if (setupPh)
        begin
            nxt_cur.slvErr = !mapped;
            nxt_cur.rdata  = '0;
            unique case (paddr)
                CTRL_OFS:     nxt_cur.rdata[0]         = cur_ff.wdtEn;
                WAKE_EN_OFS:  nxt_cur.rdata[NUM_SRC-1:0] = cur_ff.wakeEn;
                STATUS_OFS:   nxt_cur.rdata[3:0]       = {cur_ff.mode, cur_ff.toFlag,
                                                          cur_ff.pdFlag};
                INT_STAT_OFS: nxt_cur.rdata[NUM_EVT-1:0] = cur_ff.intStat;
                INT_MASK_OFS: nxt_cur.rdata[NUM_EVT-1:0] = cur_ff.intMask;
                WDT_CNT_OFS:  nxt_cur.rdata[WDT_W-1:0] = cur_ff.wdtCnt;
                default:      ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            cur_ff        <= '0;
            cur_ff.mode   <= SWC_RUN;
            cur_ff.pdFlag <= PD_RESET;
            cur_ff.toFlag <= TO_RESET;
        end
        else
        begin
            cur_ff <= nxt_cur;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign prdata        = cur_ff.rdata;
    // zero wait states: read data is staged in the setup phase
    assign pready        = 1'b1;
    assign pslverr       = psel && penable && cur_ff.slvErr;
    // the clock keeps running here; oscEnable is what stops the oscillator
    // oscillator off only while asleep
    assign oscEnable     = (cur_ff.mode != SWC_SLEEP);
    assign ioHold        = (cur_ff.mode != SWC_RUN);
    assign fetchReq      = cur_ff.fetch;
    assign fetchAddr     = cur_ff.nextPc;
    assign resumeExec    = cur_ff.resume;
    assign vectorReq     = cur_ff.vector;
    assign vectorAddr    = IRQ_VECTOR;
    assign deviceReset   = cur_ff.devRst;
    assign powerDownFlag = cur_ff.pdFlag;
    assign timeoutFlag   = cur_ff.toFlag;
    assign irqOut        = |(cur_ff.intStat & cur_ff.intMask);

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence sleepTaken;
        cur_ff.mode == SWC_RUN && sleepExec && !wakePending && !wdtExpire;
    endsequence

    sequence irqWake;
        cur_ff.mode == SWC_SLEEP && masterClearPinN && !wdtExpire && wakePending;
    endsequence

    sleep_entry_a: assert property (sleepTaken |=> cur_ff.mode == SWC_SLEEP && !powerDownFlag
        && timeoutFlag && cur_ff.wdtCnt <= WDT_W'(1) && fetchReq)
        else $error("sleep entry did not update flags");
    sleep_nop_a: assert property (cur_ff.mode == SWC_RUN && sleepExec && wakePending
        && !wdtExpire |=> cur_ff.mode == SWC_RUN && $stable(powerDownFlag)
        && $stable(timeoutFlag))
        else $error("sleep with pending interrupt was not a no-op");
    osc_stop_a: assert property (cur_ff.mode == SWC_SLEEP |-> !oscEnable && ioHold)
        else $error("oscillator running in sleep");
    wdt_wake_a: assert property (cur_ff.mode == SWC_SLEEP && masterClearPinN && wdtExpire
        |=> !timeoutFlag && cur_ff.mode == SWC_START && cur_ff.wdtCnt == '0)
        else $error("watchdog wake did not clear timeout flag");
    irq_resume_a: assert property (irqWake |=> cur_ff.mode == SWC_START
        ##(OSC_START_CYC) resumeExec)
        else $error("interrupt wake did not resume after oscillator start");
    master_clear_pin_reset_a: assert property (cur_ff.mode == SWC_SLEEP && mclrActive
        |=> deviceReset && !resumeExec)
        else $error("master clear in sleep did not reset");
    vector_gie_a: assert property (resumeExec && cur_ff.wakeByIrq && globalIrqEnable
        && !wdtExpire |=> vectorReq)
        else $error("no vector after interrupt wake");
    no_vector_a: assert property (vectorReq |-> $past(resumeExec))
        else $error("vector without preceding resume");
    prefetch_a: assert property (sleepTaken |=> fetchAddr == $past(pcValue) + PC_STEP)
        else $error("wrong prefetch address");
    wake_clear_a: assert property (cur_ff.mode == SWC_SLEEP && $past(cur_ff.mode) == SWC_SLEEP
        && !(cur_ff.wdtEn && wdtTick) |=> cur_ff.wdtCnt == '0 || cur_ff.mode == SWC_SLEEP)
        else $error("watchdog not cleared on wake");
    pd_hold_a: assert property (!sleepTaken |=> $rose(powerDownFlag) == 1'b0)
        else $error("power-down flag set outside reset");
    wdt_reset_a: assert property (cur_ff.mode == SWC_RUN && wdtExpire
        |=> deviceReset && !timeoutFlag)
        else $error("watchdog reset not internal");
    wake_enable_a: assert property (cur_ff.mode == SWC_SLEEP && (irqFlags & cur_ff.wakeEn) == '0
        && masterClearPinN && !wdtExpire |=> cur_ff.mode == SWC_SLEEP)
        else $error("wake without enabled source");
    irq_out_a: assert property (|(evt & nxt_cur.intMask) |=> irqOut)
        else $error("unmasked event did not raise the interrupt");

    // shared steps of the late wake check
    sequence lateIrq;
        sleepTaken ##1 irqWake;
    endsequence

    late_irq_a: assert property (lateIrq |-> (!powerDownFlag && timeoutFlag)
        ##1 cur_ff.mode == SWC_START)
        else $error("late interrupt did not follow a complete sleep");
    wdt_count_a: assert property (cur_ff.mode == SWC_SLEEP && cur_ff.wdtEn && wdtTick
        && !wdtExpire && !mclrActive && !wakePending
        |=> cur_ff.wdtCnt == $past(cur_ff.wdtCnt) + WDT_W'(1))
        else $error("watchdog did not count while asleep");
    wake_wdt_zero_a: assert property (irqWake |=> cur_ff.wdtCnt == '0)
        else $error("watchdog not cleared on interrupt wake");
    sleep_hold_a: assert property (sleepTaken |=> ioHold && !oscEnable)
        else $error("pins not held on sleep entry");
    vector_off_a: assert property (resumeExec && !globalIrqEnable |=> !vectorReq)
        else $error("vector taken with global enable clear");
    wdt_novec_a: assert property (resumeExec && !cur_ff.wakeByIrq |=> !vectorReq)
        else $error("vector taken after watchdog wake");
    pd_stable_a: assert property (!sleepTaken |=> $stable(powerDownFlag))
        else $error("power-down flag changed outside sleep entry");
    to_rise_a: assert property ($rose(timeoutFlag) |-> $past(sleepExec) || $past(reset))
        else $error("timeout flag set without sleep");
    irq_set_a: assert property (evt[EVT_WAKE_IRQ] |=> cur_ff.intStat[EVT_WAKE_IRQ])
        else $error("wake event lost against a clear");
    w1c_clear_a: assert property (accessWr && paddr == INT_STAT_OFS && pwdata[EVT_SLEEP]
        && !evt[EVT_SLEEP] |=> !cur_ff.intStat[EVT_SLEEP])
        else $error("write one did not clear status");
    slverr_a: assert property (setupPh && !mapped |=> !penable || pslverr)
        else $error("unmapped address not refused");
    prdata_zero_a: assert property (setupPh && !mapped |=> prdata == '0)
        else $error("unmapped read returned data");
    master_clear_pin_start_a: assert property (cur_ff.mode == SWC_START && mclrActive
        |=> deviceReset && cur_ff.mode == SWC_RUN)
        else $error("master clear during start-up did not reset");
    wdt_run_a: assert property (cur_ff.mode == SWC_RUN && wdtExpire |=> !fetchReq)
        else $error("watchdog expiry while awake entered sleep");
    fetch_once_a: assert property (fetchReq
        |-> cur_ff.mode == SWC_SLEEP && $past(cur_ff.mode) == SWC_RUN)
        else $error("prefetch outside sleep entry");
    resume_run_a: assert property (resumeExec |-> cur_ff.mode == SWC_RUN && oscEnable)
        else $error("resume before oscillator restart");
    osc_settle_a: assert property (cur_ff.mode == SWC_START && !mclrActive
        && cur_ff.oscCnt != OSC_LAST |=> !resumeExec && cur_ff.mode == SWC_START)
        else $error("resume before start-up count ended");

endmodule

// ### testbench/swc_core_model.sv
// processor core and master clear source model facing the sleep controller
`timescale 1ns/1ps
module swc_core_model
(
    input  wire logic        clk,
    output logic             sleepExec,
    output logic [12:0]      pcValue,
    output logic             watchdogClearOp,
    output logic             masterClearPinN
);
    initial
    begin
        sleepExec       = 1'b0;
        pcValue         = 13'h0000;
        watchdogClearOp = 1'b0;
        masterClearPinN = 1'b1;
    end

    // sleep op carries its own address
    task automatic doSleep(input logic [12:0] pc);
        @(posedge clk);
        sleepExec <= 1'b1;
        pcValue   <= pc;
        @(posedge clk);
        sleepExec <= 1'b0;
    endtask

    // pin drops only on an explicit external reset
    // held low several cycles, as a real reset button would be
    task automatic mclrPulse(input int n);
        @(posedge clk);
        masterClearPinN <= 1'b0;
        repeat (n) @(posedge clk);
        masterClearPinN <= 1'b1;
    endtask

    // watchdog clear op, one cycle pulse
    task automatic watchdog_clear_op();
        @(posedge clk);
        watchdogClearOp <= 1'b1;
        @(posedge clk);
        watchdogClearOp <= 1'b0;
    endtask
endmodule

// ### testbench/tb_sleep_wake_control.sv
// self-checking bench for the sleep and wake controller
`timescale 1ns/1ps
module tb_sleep_wake_control
    import swc_pkg::*;
;
    logic clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, sleepExec, watchdogClearOp, masterClearPinN;
    logic wdtTick = 1'b0, globalIrqEnable = 1'b0;
    logic [12:0] pcValue, fetchAddr, vectorAddr;
    logic [7:0]  irqFlags = 8'h00;
    logic oscEnable, ioHold, fetchReq, resumeExec, vectorReq, deviceReset;
    logic powerDownFlag, timeoutFlag, irqOut;
    int errTotal = 0, checks = 0, cyc = 0, rstSeen = 0;
    logic [7:0]  ofs [6] = '{CTRL_OFS, WAKE_EN_OFS, STATUS_OFS, INT_STAT_OFS, INT_MASK_OFS,
                             WDT_CNT_OFS};
    logic [31:0] rv  [6] = '{32'h0, 32'h0, 32'h3, 32'h0, 32'h0, 32'h0};

    always #12.5 clk = ~clk;

    sleep_wake_control #(.WDT_W(4)) sleep_wake_control_i
    (
        .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sleepExec(sleepExec), .pcValue(pcValue), .watchdogClearOp(watchdogClearOp),
        .wdtTick(wdtTick), .irqFlags(irqFlags), .globalIrqEnable(globalIrqEnable),
        .masterClearPinN(masterClearPinN), .oscEnable(oscEnable), .ioHold(ioHold),
        .fetchReq(fetchReq), .fetchAddr(fetchAddr), .resumeExec(resumeExec),
        .vectorReq(vectorReq),
        .vectorAddr(vectorAddr), .deviceReset(deviceReset), .powerDownFlag(powerDownFlag),
        .timeoutFlag(timeoutFlag), .irqOut(irqOut)
    );

    swc_core_model swc_core_model_i
    (
        .clk(clk), .sleepExec(sleepExec), .pcValue(pcValue),
        .watchdogClearOp(watchdogClearOp), .masterClearPinN(masterClearPinN)
    );

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errTotal++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task summarize();
        if (errTotal == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // request held until pready is sampled high, then released
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        penable <= 1'b0;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        e;
        apb(1'b1, a, d, rd, e);
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic        e;
        apb(1'b0, a, 32'h0, rd, e);
        chk(rd, exp);
    endtask

    // bounded so a missing wake cannot stall the run
    task automatic waitResume(input logic expVec);
        int n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end while (resumeExec !== 1'b1 && n < 300);
        chk({31'h0, resumeExec}, 32'h1);
        @(posedge clk);
        chk({31'h0, vectorReq}, {31'h0, expVec});
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (deviceReset === 1'b1)
            rstSeen++;
        if (cyc == 3000)
        begin
            errTotal++;
            summarize();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        logic [31:0] rd;
        logic        e;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        foreach (ofs[i]) rdChk(ofs[i], rv[i]);
        apb(1'b0, 8'h20, 32'h0, rd, e);
        chk({31'h0, e}, 32'h1);
        wr(WAKE_EN_OFS, 32'h1);
        wr(INT_MASK_OFS, 32'h1);
        irqFlags <= 8'h01;
        swc_core_model_i.doSleep(13'h0100);
        @(posedge clk);
        chk({31'h0, fetchReq}, 32'h0);
        rdChk(STATUS_OFS, 32'h3);
        irqFlags <= 8'h00;
        swc_core_model_i.doSleep(13'h0100);
        // outputs launched at the entry edge are seen one edge later
        @(posedge clk);
        chk({18'h0, fetchReq, fetchAddr}, 32'h2101);
        rdChk(STATUS_OFS, 32'h6);
        chk({30'h0, oscEnable, ioHold}, 32'h1);
        chk({31'h0, irqOut}, 32'h1);
        wr(INT_STAT_OFS, 32'h1);
        @(posedge clk);
        chk({31'h0, irqOut}, 32'h0);
        irqFlags <= 8'h02;
        globalIrqEnable <= 1'b1;
        repeat (8) @(posedge clk);
        rdChk(STATUS_OFS, 32'h6);
        irqFlags <= 8'h03;
        waitResume(1'b1);
        chk({19'h0, vectorAddr}, 32'h4);
        chk({31'h0, oscEnable}, 32'h1);
        rdChk(WDT_CNT_OFS, 32'h0);
        irqFlags <= 8'h00;
        globalIrqEnable <= 1'b0;
        swc_core_model_i.doSleep(13'h0200);
        irqFlags <= 8'h01;
        waitResume(1'b0);
        rdChk(STATUS_OFS, 32'h2);
        irqFlags <= 8'h00;
        wr(CTRL_OFS, 32'h1);
        swc_core_model_i.doSleep(13'h0300);
        wdtTick <= 1'b1;
        repeat (5) @(posedge clk);
        wdtTick <= 1'b0;
        rdChk(WDT_CNT_OFS, 32'h5);
        wdtTick <= 1'b1;
        repeat (11) @(posedge clk);
        wdtTick <= 1'b0;
        waitResume(1'b0);
        rdChk(STATUS_OFS, 32'h0);
        rdChk(WDT_CNT_OFS, 32'h0);
        chk(rstSeen, 32'h0);
        wr(CTRL_OFS, 32'h0);
        swc_core_model_i.doSleep(13'h0400);
        swc_core_model_i.mclrPulse(3);
        repeat (2) @(posedge clk);
        chk(rstSeen, 32'h1);
        rdChk(STATUS_OFS, 32'h2);
        wr(CTRL_OFS, 32'h1);
        wdtTick <= 1'b1;
        repeat (3) @(posedge clk);
        swc_core_model_i.watchdog_clear_op();
        wdtTick <= 1'b0;
        rdChk(WDT_CNT_OFS, 32'h0);
        wdtTick <= 1'b1;
        repeat (16) @(posedge clk);
        wdtTick <= 1'b0;
        repeat (2) @(posedge clk);
        chk(rstSeen, 32'h2);
        chk({30'h0, powerDownFlag, timeoutFlag}, 32'h0);
        summarize();
    end
endmodule
